// ==== logic/psu_cfg_pkg.sv ====
package psu_cfg_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] POLARITY_OFS = 8'h13; // First bank register
  localparam logic [7:0] DIV_TRIM_OFS = 8'h14; // Divider offset trim
  localparam logic [7:0] AMP_TRIM_OFS = 8'h15; // Amp offset trim
  localparam logic [7:0] RANGE_OPT_OFS = 8'h16; // Sense range options
  localparam logic [7:0] MODE_OPT_OFS = 8'h17; // Sense mode options
  localparam logic [7:0] FALSE_UNDERVOLTAGE_CLAMP_WORD_OFS = 8'h18; // False False_undervoltage_clamp_trim
  localparam logic [7:0] SETPOINT_OFS = 8'h19; // Load voltage trim
  localparam logic [7:0] SEL_A_OFS = 8'h1A; // Fault select A
  localparam logic [7:0] SEL_B_OFS = 8'h1B; // Fault select B
  localparam logic [7:0] STATUS_OFS = 8'h2A; // Sticky fault status
  localparam int NUM_REGS = 9; // Registers in the bank
  localparam logic [3:0] LAST_IDX = 4'h8; // Index of last register
  // Nonvolatile shadow page; shadow address is page plus offset
  localparam logic [15:0] SHADOW_BASE = 16'h8100;
  // ****************************************************************
  // Field positions in the polarity register and select B
  // ****************************************************************
  localparam int PEN_POL_BIT = 7; // Power enable polarity
  localparam int FAULT_POL_BIT = 6; // Fault output polarity
  localparam int DC_POL_BIT = 5; // Dc good polarity
  localparam int AC_POL_BIT = 4; // Ac good polarity
  localparam int GATE_POL_BIT = 3; // Series switch gate polarity
  localparam int CLAMP_BIT = 2; // Share clamp override
  localparam int DRIVE_BIT = 1; // Host drive of fault output
  localparam int CLEAR_BIT = 0; // Fault latch clear
  localparam int SEL_B_DRIVE_BIT = 2; // Host bit slot in select B
  // ****************************************************************
  // Write and read masks, reset values
  // ****************************************************************
  localparam logic [7:0] POL_READ_MASK = 8'hFA; // Bits 2, 0 read 0
  localparam logic [7:0] MODE_WR_MASK = 8'hF7; // Bit 3 reserved
  localparam logic [7:0] SEL_B_WR_MASK = 8'hFE; // Bit 0 unused
  localparam logic [7:0] FULL_MASK = 8'hFF; // All bits writable
  localparam logic [7:0] CFG_RESET = 8'h00; // Value before loading
  // ****************************************************************
  // Power-up loader states
  // ****************************************************************
  typedef enum logic [2:0] {
    LD_REQ = 3'b001,
    LD_WAIT = 3'b010,
    LD_RUN = 3'b100
  } loader_state_t;
endpackage : psu_cfg_pkg

// ==== logic/psu_config_and_fault_select_regs.sv ====
`timescale 1ns/1ns
// Operation
// - Load each bank register from shadow at power-up
// - Bits 7..4 set four output polarities
// - Bit 3 sets gate polarity, 0 inverted
// - Write-only bit 2 forces share clamp
// - Bit 1 lets host drive fault output
// - Bit 0 clears latched fault indicator
// - Register 14h holds divider offset trim word
// - Register 15h holds amp offset trim word
// - Register 18h holds false undervoltage clamp word
// - Register 19h holds output setpoint trim word
// - Register 1Ah enables eight fault sources
// - Register 1Bh enables seven further sources
// - Latch mode bit picks latching fault indicator
// - Status read clears flags unless fault persists
module psu_config_and_fault_select_regs (
  input wire logic clk_sys_i, // System clock, 25 MHz
  input wire logic reset_n_i, // Async power-up reset
  input wire logic ce_i, // Clock enable, freezes state
  input wire logic [7:0] reg_addr_i, // Register offset
  input wire logic reg_wr_i, // Write strobe
  input wire logic [7:0] reg_wdata_i, // Write data
  input wire logic reg_rd_i, // Read strobe
  output logic [7:0] reg_rdata_o, // Read data, one cycle later
  output logic nvm_rd_o, // Shadow read request
  output logic [15:0] nvm_addr_o, // Shadow address
  input wire logic nvm_ack_i, // Shadow data valid
  input wire logic [7:0] nvm_data_i, // Shadow data
  output logic config_ready_o, // Bank loaded
  input wire logic latch_mode_i, // Fault indicator latch mode
  input wire logic power_enable_i, // Internal power enable
  input wire logic dc_good_i, // Internal dc good
  input wire logic ac_good_i, // Internal ac good
  input wire logic switch_on_i, // Internal series switch on
  input wire logic [7:0] fault_src_a_i, // Sources for select A
  input wire logic supply_good_n_i, // Supply not good
  input wire logic [4:0] monitor_flag_i, // Monitor flags one..five
  output logic power_enable_out_o, // Power enable pin
  output logic fault_out_o, // Fault indicator pin
  output logic dc_good_out_o, // Dc good pin
  output logic ac_good_out_o, // Ac good pin
  output logic gate_out_o, // Series switch gate
  output logic share_clamp_o, // Share clamp asserted
  output logic alert_o, // Alert request, active high
  output logic [7:0] divider_offset_trim_word_o, // Divider trim
  output logic [7:0] amp_offset_trim_word_o, // Amp offset trim
  output logic [7:0] sense_range_o, // Sense range options
  output logic [7:0] sense_mode_o, // Sense mode options
  output logic [7:0] false_undervoltage_clamp_word_o, // False_undervoltage_clamp_word
  output logic [7:0] setpoint_trim_word_o // Load voltage trim
);
  import psu_cfg_pkg::*;

  // ****************************************************************
  // Storage and decode
  // ****************************************************************
  logic [7:0] cfg [NUM_REGS]; // Register bank, indexed from 13h
  loader_state_t ld_state; // Loader state
  logic [3:0] ld_idx; // Register being loaded
  logic clamp_ovr; // Write-only share clamp override
  logic fault_latched; // Latched fault indicator
  logic [7:0] status; // Sticky fault status flags
  logic [7:0] status_src; // Live status conditions
  logic in_bank; // Address falls in the bank
  logic [3:0] wr_idx; // Bank index of the address
  logic bank_wr; // Accepted write into the bank
  logic clear_pulse; // Host clear of fault latch
  logic status_rd; // Read of the status register
  logic [7:0] src_b; // Select B source vector
  logic fault_raw; // OR of enabled sources
  logic next_latched; // Next latch value
  logic fault_active; // Indicator before polarity
  logic loaded; // Loader done

  assign loaded = (ld_state == LD_RUN);
  assign in_bank = (reg_addr_i >= POLARITY_OFS)
                   && (reg_addr_i <= SEL_B_OFS);
  assign wr_idx = 4'(reg_addr_i - POLARITY_OFS);
  // Writes before loading would be overwritten, so refuse them
  assign bank_wr = reg_wr_i && in_bank && loaded;
  assign clear_pulse = reg_wr_i && loaded && (reg_addr_i == POLARITY_OFS)
                       && reg_wdata_i[CLEAR_BIT];
  assign status_rd = reg_rd_i && (reg_addr_i == STATUS_OFS);

  // Per-register write mask; reserved and unused bits hold zero
  function automatic logic [7:0] wr_mask(input logic [3:0] idx);
    logic [7:0] m;
    m = FULL_MASK;
    if (idx == 4'(MODE_OPT_OFS - POLARITY_OFS)) begin
      m = MODE_WR_MASK;
    end else if (idx == 4'(SEL_B_OFS - POLARITY_OFS)) begin
      m = SEL_B_WR_MASK;
    end
    return m;
  endfunction : wr_mask

  // Apply a polarity bit: 1 passes the level, 0 inverts it
  function automatic logic polar(input logic pol, input logic lvl);
    return pol ? lvl : ~lvl;
  endfunction : polar

  // ****************************************************************
  // Power-up loader
  // ****************************************************************
  // Walks the bank once, one shadow read per register
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ld_state <= LD_REQ;
      ld_idx <= 4'h0;
    end else if (ce_i) begin
      unique case (ld_state)
        LD_REQ: begin
          ld_state <= LD_WAIT;
        end
        LD_WAIT: begin
          // Hold the request until the shadow answers
          if (nvm_ack_i) begin
            if (ld_idx == LAST_IDX) begin
              ld_state <= LD_RUN;
            end else begin
              ld_idx <= ld_idx + 4'h1;
              ld_state <= LD_REQ;
            end
          end
        end
        LD_RUN: begin
          ld_state <= LD_RUN;
        end
        default: begin
          ld_state <= LD_REQ;
        end
      endcase
    end
  end

  // Shadow port signals, all from flops
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nvm_rd_o <= 1'b0;
      nvm_addr_o <= SHADOW_BASE;
      config_ready_o <= 1'b0;
    end else if (ce_i) begin
      nvm_rd_o <= (ld_state == LD_REQ)
                  || ((ld_state == LD_WAIT) && !nvm_ack_i);
      nvm_addr_o <= SHADOW_BASE + 16'(POLARITY_OFS) + 16'(ld_idx);
      config_ready_o <= loaded;
    end
  end

  // ****************************************************************
  // Register bank
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_bank
      // Loaded from shadow first, then host writes
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          cfg[gi] <= CFG_RESET;
        end else if (ce_i) begin
          if ((ld_state == LD_WAIT) && nvm_ack_i && (ld_idx == 4'(gi))) begin
            cfg[gi] <= nvm_data_i & wr_mask(4'(gi));
          end else if (bank_wr && (wr_idx == 4'(gi))) begin
            cfg[gi] <= reg_wdata_i & wr_mask(4'(gi));
          end
        end
      end
    end
  endgenerate

  // Share clamp override follows bit 2 of the polarity register
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clamp_ovr <= 1'b0;
    end else if (ce_i) begin
      clamp_ovr <= cfg[0][CLAMP_BIT];
    end
  end

  // Read data; write-only bits mask to zero
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i && reg_rd_i) begin
      if (reg_addr_i == POLARITY_OFS) begin
        reg_rdata_o <= cfg[0] & POL_READ_MASK;
      end else if (in_bank) begin
        reg_rdata_o <= cfg[wr_idx];
      end else if (reg_addr_i == STATUS_OFS) begin
        reg_rdata_o <= status;
      end else begin
        reg_rdata_o <= 8'h00; // Unmapped reads as zero
      end
    end
  end

  // ****************************************************************
  // Fault selection and indicator
  // ****************************************************************
  // Slot 2 of select B is the host drive bit itself
  assign src_b = {supply_good_n_i, monitor_flag_i[0], monitor_flag_i[1],
                  monitor_flag_i[2], monitor_flag_i[3],
                  cfg[0][DRIVE_BIT], monitor_flag_i[4], 1'b0};
  assign fault_raw = |(cfg[7] & fault_src_a_i)
                     || |(cfg[8] & src_b);
  // A new fault in the clear cycle wins over the clear
  assign next_latched = fault_raw
                        || (fault_latched && !clear_pulse);
  assign fault_active = latch_mode_i ? next_latched : fault_raw;

  // Latch only runs in latching mode
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_latched <= 1'b0;
    end else if (ce_i) begin
      fault_latched <= latch_mode_i && next_latched;
    end
  end

  // Output pins; held inactive-low until the bank is loaded
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_enable_out_o <= 1'b0;
      fault_out_o <= 1'b0;
      dc_good_out_o <= 1'b0;
      ac_good_out_o <= 1'b0;
      gate_out_o <= 1'b0;
      share_clamp_o <= 1'b0;
      alert_o <= 1'b0;
    end else if (ce_i && loaded) begin
      power_enable_out_o <= polar(cfg[0][PEN_POL_BIT],
                                  power_enable_i);
      fault_out_o <= polar(cfg[0][FAULT_POL_BIT], fault_active);
      dc_good_out_o <= polar(cfg[0][DC_POL_BIT], dc_good_i);
      ac_good_out_o <= polar(cfg[0][AC_POL_BIT], ac_good_i);
      gate_out_o <= polar(cfg[0][GATE_POL_BIT], switch_on_i);
      share_clamp_o <= clamp_ovr;
      alert_o <= fault_active;
    end
  end

  // Trim and option words are the bank flops themselves
  assign divider_offset_trim_word_o = cfg[1];
  assign amp_offset_trim_word_o = cfg[2];
  assign sense_range_o = cfg[3];
  assign sense_mode_o = cfg[4];
  assign false_undervoltage_clamp_word_o = cfg[5];
  assign setpoint_trim_word_o = cfg[6];

  // ****************************************************************
  // Sticky status, cleared by read
  // ****************************************************************
  // Flag one sits at bit 4 and flag five at bit 0, so the order flips
  assign status_src = {fault_src_a_i[7:5], monitor_flag_i[0],
                       monitor_flag_i[1], monitor_flag_i[2],
                       monitor_flag_i[3], monitor_flag_i[4]};

  // Set wins over the read clear; a present fault survives the read
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status <= 8'h00;
    end else if (ce_i) begin
      if (status_rd) begin
        status <= status_src;
      end else begin
        status <= status | status_src;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  ready_after_ack_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(config_ready_o) |-> $past(nvm_ack_i, 2))
    else $error("bank ready without a final shadow answer");

  pen_polarity_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (ce_i && loaded) |=> power_enable_out_o
      == ($past(cfg[0][PEN_POL_BIT]) ? $past(power_enable_i)
          : !$past(power_enable_i)))
    else $error("power enable polarity wrong");

  gate_polarity_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (ce_i && loaded && !cfg[0][GATE_POL_BIT] && switch_on_i)
      |=> !gate_out_o)
    else $error("inverted gate not low when on");

  clamp_override_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (bank_wr && ce_i && reg_addr_i == POLARITY_OFS
      && reg_wdata_i[CLAMP_BIT]) ##1 ce_i ##1 ce_i |=> share_clamp_o)
    else $error("share clamp not asserted after write");

  latch_clear_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (ce_i && clear_pulse && !fault_raw) |=> !fault_latched)
    else $error("fault latch not cleared");

  divider_trim_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (ce_i && bank_wr && reg_addr_i == DIV_TRIM_OFS)
      |=> divider_offset_trim_word_o == $past(reg_wdata_i))
    else $error("divider trim not stored");

  setpoint_trim_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (ce_i && bank_wr && reg_addr_i == SETPOINT_OFS)
      |=> setpoint_trim_word_o == $past(reg_wdata_i))
    else $error("setpoint trim not stored");

  alert_select_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (ce_i && loaded && !latch_mode_i) |=>
      alert_o == ($past(|(cfg[7] & fault_src_a_i))
                  || $past(|(cfg[8] & src_b))))
    else $error("alert does not follow enabled sources");

  status_clear_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (ce_i && status_rd && !status_src[7]) |=> !status[7])
    else $error("status flag survived read");

  write_only_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (ce_i && reg_rd_i && reg_addr_i == POLARITY_OFS)
      |=> !reg_rdata_o[CLAMP_BIT] && !reg_rdata_o[CLEAR_BIT])
    else $error("write-only bit read back nonzero");

  load_done_c: cover property (
    @(posedge clk_sys_i) disable iff (!reset_n_i) $rose(config_ready_o));

  latched_clear_c: cover property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    fault_latched ##1 clear_pulse ##1 !fault_latched);

  status_read_c: cover property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (status != 8'h00) ##1 status_rd);
endmodule : psu_config_and_fault_select_regs

// ==== tb/nvm_shadow_model.sv ====
`timescale 1ns/1ns
// ****************************************************************
// Shadow memory answering the bank loader
// ****************************************************************
module nvm_shadow_model (
  input wire logic clk_sys_i, // System clock
  input wire logic reset_n_i, // Async reset
  input wire logic nvm_rd_i, // Read request
  input wire logic [15:0] nvm_addr_i, // Shadow address
  output logic nvm_ack_o, // One-cycle data valid
  output logic [7:0] nvm_data_o // Shadow byte
);
  logic [1:0] wait_cnt; // Cycles stalled on this request
  // Odd addresses answer at once, even ones stall three cycles
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nvm_ack_o <= 1'b0;
      nvm_data_o <= 8'hC3;
      wait_cnt <= 2'h0;
    end else if (nvm_ack_o || !nvm_rd_i) begin
      // Data not held past ack, so a late sample sees junk
      nvm_ack_o <= 1'b0;
      nvm_data_o <= ~nvm_data_o;
      wait_cnt <= 2'h0;
    end else if (nvm_addr_i[0] || wait_cnt == 2'h3) begin
      nvm_ack_o <= 1'b1;
      nvm_data_o <= (nvm_addr_i[7:0] * 8'h1D) ^ 8'h5A;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
      nvm_data_o <= ~nvm_data_o;
    end
  end
endmodule : nvm_shadow_model

// ==== tb/psu_config_and_fault_select_regs_test.sv ====
`timescale 1ns/1ns
module psu_config_and_fault_select_regs_test;
  import psu_cfg_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk_sys_i, reset_n_i, ce_i, reg_wr_i, reg_rd_i; // Bus side
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o; // Register port
  logic nvm_rd_o, nvm_ack_i, config_ready_o; // Loader handshake
  logic [15:0] nvm_addr_o; // Shadow address
  logic [7:0] nvm_data_i, fault_src_a_i; // Shadow data, sources
  logic latch_mode_i, power_enable_i, dc_good_i, ac_good_i; // Levels
  logic switch_on_i, supply_good_n_i; // Levels
  logic [4:0] monitor_flag_i; // Monitor flags one..five
  logic power_enable_out_o, fault_out_o, dc_good_out_o; // Pins
  logic ac_good_out_o, gate_out_o, share_clamp_o, alert_o; // Pins
  logic [7:0] div_t, amp_t, rng_t, mode_t, uv_t, set_t; // Trim ports
  logic [7:0] pol, sel_a, sel_b, rd_val, ofs, val; // Bench state
  logic [3:0] ld_idx; // Shadow reads seen
  logic [6:0] exp_pins; // Expected pin vector
  logic [7:0] trim_ofs [6]; // Trim offsets used at random
  int bad_count, cmp_count; // Mismatches, comparisons
  psu_config_and_fault_select_regs u_dut (.clk_sys_i, .reset_n_i,
    .ce_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
    .reg_rdata_o, .nvm_rd_o, .nvm_addr_o, .nvm_ack_i, .nvm_data_i,
    .config_ready_o, .latch_mode_i, .power_enable_i, .dc_good_i,
    .ac_good_i, .switch_on_i, .fault_src_a_i, .supply_good_n_i,
    .monitor_flag_i, .power_enable_out_o, .fault_out_o,
    .dc_good_out_o, .ac_good_out_o, .gate_out_o, .share_clamp_o,
    .alert_o, .divider_offset_trim_word_o(div_t),
    .amp_offset_trim_word_o(amp_t), .sense_range_o(rng_t),
    .sense_mode_o(mode_t), .false_undervoltage_clamp_word_o(uv_t),
    .setpoint_trim_word_o(set_t));
  nvm_shadow_model u_nvm (.clk_sys_i, .reset_n_i, .nvm_rd_i(nvm_rd_o),
    .nvm_addr_i(nvm_addr_o), .nvm_ack_o(nvm_ack_i),
    .nvm_data_o(nvm_data_i));
  // ****************************************************************
  // Expectation helpers
  // ****************************************************************
  function automatic logic [7:0] shadow_byte(input logic [7:0] o);
    return (o * 8'h1D) ^ 8'h5A;
  endfunction : shadow_byte
  // Bits that read back as stored
  function automatic logic [7:0] rmask(input logic [7:0] o);
    case (o)
      POLARITY_OFS: return POL_READ_MASK;
      MODE_OPT_OFS: return MODE_WR_MASK;
      SEL_B_OFS: return SEL_B_WR_MASK;
      default: return FULL_MASK;
    endcase
  endfunction : rmask
  function automatic logic [7:0] trim_port(input logic [7:0] o);
    case (o)
      DIV_TRIM_OFS: return div_t;
      AMP_TRIM_OFS: return amp_t;
      RANGE_OPT_OFS: return rng_t;
      MODE_OPT_OFS: return mode_t;
      FALSE_UNDERVOLTAGE_CLAMP_WORD_OFS: return uv_t;
      default: return set_t;
    endcase
  endfunction : trim_port
  // Enabled sources ORed, before polarity
  function automatic logic fault_active();
    logic [7:0] src_b;
    src_b = {supply_good_n_i, monitor_flag_i[0], monitor_flag_i[1],
      monitor_flag_i[2], monitor_flag_i[3], pol[DRIVE_BIT],
      monitor_flag_i[4], 1'b0};
    return (|(fault_src_a_i & sel_a)) || (|(src_b & sel_b));
  endfunction : fault_active
  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic reg_write(input logic [7:0] o, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_i = o;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask : reg_write
  // Data is registered, so it is settled one negedge later
  task automatic reg_read(input logic [7:0] o);
    @(negedge clk_sys_i);
    reg_addr_i = o;
    reg_rd_i = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_i = 1'b0;
    rd_val = reg_rdata_o;
  endtask : reg_read
  // One-cycle overvoltage pulse, then settle
  task automatic ov_pulse();
    @(negedge clk_sys_i);
    fault_src_a_i = 8'h80;
    @(negedge clk_sys_i);
    fault_src_a_i = 8'h00;
    repeat (3) @(negedge clk_sys_i);
  endtask : ov_pulse
  // Reset, wait for the loader, compare every loaded register
  task automatic power_up();
    int n;
    reset_n_i = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    n = 0;
    while (config_ready_o !== 1'b1 && n < 300) begin
      @(negedge clk_sys_i);
      n++;
    end
    check("load count", 16'(ld_idx), 16'h9);
    for (int i = 0; i < NUM_REGS; i++) begin
      ofs = POLARITY_OFS + 8'(i);
      reg_read(ofs);
      check("loaded", rd_val, shadow_byte(ofs) & rmask(ofs));
    end
    check("load trim", set_t, shadow_byte(SETPOINT_OFS));
  endtask : power_up
  task automatic finish_test();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  // Shadow reads must walk up the page in order; count restarts in reset
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ld_idx <= 4'h0;
    end else if (nvm_rd_o && nvm_ack_i) begin
      check("shadow addr", nvm_addr_o,
        SHADOW_BASE + 16'(POLARITY_OFS) + 16'(ld_idx));
      ld_idx <= ld_idx + 4'h1;
    end
  end
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // Watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    finish_test();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {ce_i, reg_wr_i, reg_rd_i, latch_mode_i} = 4'h8;
    {reg_addr_i, reg_wdata_i, fault_src_a_i} = 24'h0;
    {power_enable_i, dc_good_i, ac_good_i, switch_on_i} = 4'h0;
    {supply_good_n_i, monitor_flag_i} = 6'h0;
    trim_ofs = '{DIV_TRIM_OFS, AMP_TRIM_OFS, RANGE_OPT_OFS,
      MODE_OPT_OFS, FALSE_UNDERVOLTAGE_CLAMP_WORD_OFS, SETPOINT_OFS};
    void'($urandom(32'h10D2));
    power_up();
    // Random polarity, selects and sources; corners first
    for (int k = 0; k < 30; k++) begin
      pol = (k == 0) ? 8'h00 : (k == 1) ? 8'hFE : 8'($urandom) & 8'hFE;
      sel_a = 8'($urandom);
      sel_b = (k == 1) ? 8'h04 : 8'($urandom);
      reg_write(POLARITY_OFS, pol);
      reg_write(SEL_A_OFS, sel_a);
      reg_write(SEL_B_OFS, sel_b);
      {power_enable_i, dc_good_i, ac_good_i, switch_on_i} = 4'($urandom);
      supply_good_n_i = 1'($urandom);
      fault_src_a_i = 8'($urandom) & 8'($urandom);
      monitor_flag_i = 5'($urandom) & 5'($urandom);
      repeat (3) @(negedge clk_sys_i);
      exp_pins = {power_enable_i ~^ pol[PEN_POL_BIT],
        fault_active() ~^ pol[FAULT_POL_BIT], dc_good_i ~^ pol[DC_POL_BIT],
        ac_good_i ~^ pol[AC_POL_BIT], switch_on_i ~^ pol[GATE_POL_BIT],
        pol[CLAMP_BIT], fault_active()};
      check("pins", {power_enable_out_o, fault_out_o, dc_good_out_o,
        ac_good_out_o, gate_out_o, share_clamp_o, alert_o},
        exp_pins);
      reg_read(POLARITY_OFS);
      check("pol read", rd_val, pol & POL_READ_MASK);
      reg_read(SEL_B_OFS);
      check("sel b read", rd_val, sel_b & SEL_B_WR_MASK);
      ofs = trim_ofs[$urandom_range(5)];
      val = 8'($urandom);
      reg_write(ofs, val);
      reg_read(ofs);
      check("trim read", rd_val, val & rmask(ofs));
      check("trim port", trim_port(ofs), val & rmask(ofs));
    end
    // Latching indicator; clear refused while fault persists
    {supply_good_n_i, monitor_flag_i, fault_src_a_i} = 14'h0;
    pol = 8'hC0;
    reg_write(SEL_A_OFS, 8'h80);
    reg_write(SEL_B_OFS, 8'h00);
    reg_write(POLARITY_OFS, pol);
    latch_mode_i = 1'b1;
    ov_pulse();
    check("latched", {fault_out_o, alert_o}, 2'h3);
    fault_src_a_i = 8'h80;
    reg_write(POLARITY_OFS, pol | 8'h01);
    fault_src_a_i = 8'h00;
    repeat (3) @(negedge clk_sys_i);
    check("clear vs fault", {fault_out_o, alert_o}, 2'h3);
    reg_write(POLARITY_OFS, pol | 8'h01);
    repeat (3) @(negedge clk_sys_i);
    check("cleared", {fault_out_o, alert_o}, 2'h0);
    latch_mode_i = 1'b0;
    ov_pulse();
    check("follows", {fault_out_o, alert_o}, 2'h0);
    // Sticky status, cleared by read unless still present
    reg_read(STATUS_OFS);
    ov_pulse();
    monitor_flag_i = 5'h01;
    repeat (2) @(negedge clk_sys_i);
    reg_read(STATUS_OFS);
    check("status", rd_val, 8'h90);
    reg_read(STATUS_OFS);
    check("status held", rd_val, 8'h10);
    monitor_flag_i = 5'h00;
    repeat (2) @(negedge clk_sys_i);
    reg_read(STATUS_OFS);
    reg_read(STATUS_OFS);
    check("status clear", rd_val, 8'h00);
    // Unmapped place: write ignored, read gives zero
    val = set_t;
    reg_write(8'h20, 8'hFF);
    reg_read(8'h1C);
    check("unmapped", rd_val, 8'h00);
    check("no alias", set_t, val);
    // Enable low freezes the bank, so this write is not taken
    ce_i = 1'b0;
    reg_write(SETPOINT_OFS, ~val);
    check("frozen", set_t, val);
    ce_i = 1'b1;
    power_up();
    finish_test();
  end
endmodule : psu_config_and_fault_select_regs_test
